// ==== src/lsc_lo_console.sv ====
// LO synthesizer console command engine with a Wishbone register port
//
// Summary of operation
// - Channel 0-3 and path pick synthesizer
// - Readback refreshes whole buffered copy from synthesizer
// - Direct write puts bytes into synthesizer
// - One to eight bytes, ascending addresses
// - Direct read returns counted bytes, then acknowledge
// - Buffered write touches only local copy
// - Commit moves buffered copy into synthesizer
// - Buffered read never touches synthesizer
// - LO frequency runs filter, source, output, enables, commit
// - LO frequency limited 21600000 to 41000000 kHz
// - LO frequency query returns held kHz value
// - LO source: connector, synthesizer, doubled synthesizer
// - LO source query reports selection
// - Reference routing per channel, source and mode
// - Outside reference only with output off
// - Primary reference only in follower role
// - Output modes drive connector, never with outside source
// - Reference query returns source then mode
// - Commit writes full held parameter set
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`include "lsc_params.svh"
`default_nettype none
module lsc_lo_console (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output lsc_pkg::lsc_synth_req_t synth_req_out,
  output logic synth_valid_out,
  input wire logic synth_ack_in,
  input wire logic [7:0] synth_rdata_in,
  output lsc_pkg::lsc_path_cfg_t [7:0] path_cfg_out,
  output lsc_pkg::lsc_ref_cfg_t [3:0] ref_cfg_out,
  output logic [3:0] ref_conn_oe_out,
  output logic busy_out
);
  import lsc_pkg::*;

  // ==========================================================
  // Wishbone register file
  // ==========================================================
  logic [14:0] cmd_addr; // Start register address
  logic [3:0] cmd_count; // Byte count
  logic [7:0][7:0] cmd_data; // Bytes to write
  logic [31:0] cmd_arg; // Frequency or source arguments
  logic follower; // Unit role setting, 1 = follower
  logic [14:0] next_cmd_addr;
  logic [3:0] next_cmd_count;
  logic [7:0][7:0] next_cmd_data;
  logic [31:0] next_cmd_arg;
  logic next_follower;
  logic next_ack;
  logic [31:0] next_rdat;
  logic [31:0] wmask; // Byte lane mask from select
  logic wr_edge; // Write takes effect this edge
  logic launch; // Command start accepted
  logic in_map; // Address inside the block window

  // Engine state seen by the bus
  lsc_state_t st;
  logic done_flag;
  logic err_flag;
  logic [7:0][7:0] resp;
  logic [31:0] result;

  assign wr_edge = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
  assign in_map = (wb_adr_in[31:6] == 26'h0);
  // Launch only when idle, so a command never overlaps the last one
  assign launch = wr_edge && in_map && (wb_adr_in[5:0] == `LSC_OFF_CMD)
    && wb_sel_in[3] && wb_sel_in[0] && wb_dat_in[`LSC_CMD_GO_BIT]
    && (st == ST_IDLE);

  // Next values of the bus registers
  always_comb begin
    wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
      {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    next_ack = wb_cyc_in && wb_stb_in && !wb_ack_out;
    next_rdat = wb_dat_out;
    next_cmd_addr = cmd_addr;
    next_cmd_count = cmd_count;
    next_cmd_data = cmd_data;
    next_cmd_arg = cmd_arg;
    next_follower = follower;
    // Read data is ready together with ack
    if (next_ack) begin
      case (wb_adr_in[5:0])
        `LSC_OFF_ADDR: next_rdat = {12'h0, cmd_count, 1'b0, cmd_addr};
        `LSC_OFF_DATA0: next_rdat = cmd_data[3:0];
        `LSC_OFF_DATA1: next_rdat = cmd_data[7:4];
        `LSC_OFF_ARG: next_rdat = cmd_arg;
        `LSC_OFF_STATUS: next_rdat = {29'h0, err_flag, done_flag,
          (st != ST_IDLE)};
        `LSC_OFF_RESP0: next_rdat = resp[3:0];
        `LSC_OFF_RESP1: next_rdat = resp[7:4];
        `LSC_OFF_RESULT: next_rdat = result;
        `LSC_OFF_ROLE: next_rdat = {31'h0, follower};
        default: next_rdat = 32'h0; // Command and unmapped read zero
      endcase
      if (!in_map) begin
        next_rdat = 32'h0;
      end
    end
    // Writes land on the acknowledging edge
    if (wr_edge && in_map) begin
      case (wb_adr_in[5:0])
        `LSC_OFF_ADDR: begin
          {next_cmd_count, next_cmd_addr} = {cmd_count, cmd_addr};
          if (wb_sel_in[0]) next_cmd_addr[7:0] = wb_dat_in[7:0];
          if (wb_sel_in[1]) next_cmd_addr[14:8] = wb_dat_in[14:8];
          if (wb_sel_in[2]) next_cmd_count = wb_dat_in[19:16];
        end
        `LSC_OFF_DATA0: next_cmd_data[3:0] = (cmd_data[3:0] & ~wmask)
          | (wb_dat_in & wmask);
        `LSC_OFF_DATA1: next_cmd_data[7:4] = (cmd_data[7:4] & ~wmask)
          | (wb_dat_in & wmask);
        `LSC_OFF_ARG: next_cmd_arg = (cmd_arg & ~wmask)
          | (wb_dat_in & wmask);
        `LSC_OFF_ROLE: begin
          if (wb_sel_in[0]) next_follower = wb_dat_in[0];
        end
        default: next_follower = follower; // Others ignored
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
      cmd_addr <= 15'h0;
      cmd_count <= 4'h0;
      cmd_data <= 64'h0;
      cmd_arg <= 32'h0;
      follower <= 1'b0;
    end else begin
      wb_ack_out <= next_ack;
      wb_dat_out <= next_rdat;
      cmd_addr <= next_cmd_addr;
      cmd_count <= next_cmd_count;
      cmd_data <= next_cmd_data;
      cmd_arg <= next_cmd_arg;
      follower <= next_follower;
    end
  end

  // ==========================================================
  // Buffered register copy, one bank per synthesizer
  // ==========================================================
  logic [7:0] buf_mem [0:1023]; // Eight banks of held bytes
  logic buf_we;
  logic [9:0] buf_widx;
  logic [7:0] buf_wdata;
  logic [9:0] buf_ridx;
  logic [7:0] buf_rd;

  // Memory write port, no reset on contents
  always_ff @(posedge mclk_in) begin
    if (buf_we) begin
      buf_mem[buf_widx] <= buf_wdata;
    end
  end

  // ==========================================================
  // Command engine
  // ==========================================================
  lsc_op_t op; // Command in progress
  logic [2:0] inst; // {channel, path}
  lsc_xfer_t kind; // Current byte loop
  logic [7:0] idx; // Bytes done in loop
  logic [7:0] cnt; // Bytes in loop
  logic [14:0] base; // Loop start address
  lsc_path_cfg_t [7:0] path_cfg;
  lsc_ref_cfg_t [3:0] ref_cfg;
  lsc_synth_req_t req;
  logic req_valid;
  lsc_state_t next_st;
  lsc_op_t next_op;
  logic [2:0] next_inst;
  lsc_xfer_t next_kind;
  logic [7:0] next_idx;
  logic [7:0] next_cnt;
  logic [14:0] next_base;
  lsc_path_cfg_t [7:0] next_path_cfg;
  lsc_ref_cfg_t [3:0] next_ref_cfg;
  lsc_synth_req_t next_req;
  logic next_req_valid;
  logic next_done;
  logic next_err;
  logic [7:0][7:0] next_resp;
  logic [31:0] next_result;
  logic chk_err; // Arguments of command rejected
  logic step; // One byte finished
  logic xfer_last; // Finished byte is the last
  logic [15:0] buf_end; // End of buffered range
  logic [6:0] boff; // Offset inside a bank
  lsc_path_cfg_t pc;

  assign xfer_last = ((idx + 8'h01) == cnt);
  assign boff = base[6:0] + idx[6:0];
  assign buf_ridx = {inst, boff};
  assign buf_rd = buf_mem[buf_ridx];
  assign buf_end = {1'b0, cmd_addr} + {12'h0, cmd_count};

  // Argument checks against the command in progress
  always_comb begin
    case (op)
      OP_DWRITE, OP_DREAD: chk_err = (cmd_count == 4'h0)
        || (cmd_count > `LSC_MAX_BYTES);
      OP_BWRITE, OP_BREAD: chk_err = (cmd_count == 4'h0)
        || (cmd_count > `LSC_MAX_BYTES)
        || (buf_end > {8'h0, `LSC_BUF_DEPTH});
      OP_LO_FREQ: chk_err = (cmd_arg[25:0] < `LSC_FREQ_MIN_KHZ)
        || (cmd_arg[25:0] > `LSC_FREQ_MAX_KHZ)
        || (cmd_arg[31:26] != 6'h0);
      OP_LO_SRC: chk_err = (cmd_arg[1:0] == 2'h3);
      OP_REF: chk_err = (cmd_arg[1:0] == 2'h3)
        || (cmd_arg[5:4] == 2'h3)
        || ((cmd_arg[1:0] == REF_OUTSIDE_CONNECTOR)
          && (cmd_arg[5:4] != RMODE_OFF))
        || ((cmd_arg[1:0] == REF_PRIMARY) && !follower);
      OP_READBACK, OP_COMMIT, OP_LO_FREQ_Q, OP_LO_SRC_Q,
      OP_REF_Q: chk_err = 1'b0;
      default: chk_err = 1'b1; // Unknown command code
    endcase
  end

  // Next values of the engine
  always_comb begin
    next_st = st;
    next_op = op;
    next_inst = inst;
    next_kind = kind;
    next_idx = idx;
    next_cnt = cnt;
    next_base = base;
    next_path_cfg = path_cfg;
    next_ref_cfg = ref_cfg;
    next_req = req;
    next_req_valid = req_valid;
    next_done = done_flag;
    next_err = err_flag;
    next_resp = resp;
    next_result = result;
    buf_we = 1'b0;
    buf_widx = buf_ridx;
    buf_wdata = 8'h0;
    step = 1'b0;
    pc = path_cfg[inst];
    case (st)
      // Wait for a start; clear the acknowledge of the last one
      ST_IDLE: begin
        if (launch) begin
          next_st = ST_EXEC;
          next_op = lsc_op_t'(wb_dat_in[3:0]);
          next_inst = {wb_dat_in[5:4], wb_dat_in[`LSC_CMD_PATH_BIT]};
          next_done = 1'b0;
          next_err = 1'b0;
          next_resp = 64'h0;
        end
      end
      // Check arguments, run local commands, set up loops
      ST_EXEC: begin
        next_idx = 8'h0;
        next_base = cmd_addr;
        next_cnt = {4'h0, cmd_count};
        next_st = ST_IDLE;
        if (chk_err) begin
          next_err = 1'b1;
          next_done = 1'b1;
        end else begin
          case (op)
            OP_READBACK: begin
              next_kind = XK_READBACK;
              next_base = 15'h0;
              next_cnt = `LSC_BUF_DEPTH;
              next_st = ST_XFER;
            end
            OP_DWRITE: begin
              next_kind = XK_DWRITE;
              next_st = ST_XFER;
            end
            OP_DREAD: begin
              next_kind = XK_DREAD;
              next_st = ST_XFER;
            end
            OP_BWRITE: begin
              next_kind = XK_BWRITE;
              next_st = ST_XFER;
            end
            OP_BREAD: begin
              next_kind = XK_BREAD;
              next_st = ST_XFER;
            end
            OP_COMMIT: begin
              next_kind = XK_COMMIT;
              next_base = 15'h0;
              next_cnt = `LSC_BUF_DEPTH;
              next_st = ST_XFER;
            end
            OP_LO_FREQ: begin
              // Filter, source, output, enables, then commit
              pc.filt_wide = (cmd_arg[25:0] >= `LSC_BW_SPLIT_KHZ);
              pc.lo_src = LO_DOUBLED_SYNTH;
              pc.out_khz = 23'(cmd_arg[25:0] >> `LSC_LO_MULT_SHIFT);
              pc.rf8_en = 1'b0;
              pc.rf16_en = 1'b1;
              pc.lo_khz = cmd_arg[25:0];
              next_path_cfg[inst] = pc;
              next_kind = XK_COMMIT;
              next_base = 15'h0;
              next_cnt = `LSC_BUF_DEPTH;
              next_st = ST_XFER;
            end
            OP_LO_FREQ_Q: next_result = {6'h0, pc.lo_khz};
            OP_LO_SRC: begin
              pc.lo_src = lsc_lo_src_t'(cmd_arg[1:0]);
              next_path_cfg[inst] = pc;
            end
            OP_LO_SRC_Q: next_result = {30'h0, pc.lo_src};
            OP_REF: begin
              next_ref_cfg[inst[2:1]].src =
                lsc_ref_src_t'(cmd_arg[1:0]);
              next_ref_cfg[inst[2:1]].mode =
                lsc_ref_mode_t'(cmd_arg[5:4]);
            end
            OP_REF_Q: next_result = {26'h0, ref_cfg[inst[2:1]].mode,
              2'h0, ref_cfg[inst[2:1]].src};
            default: next_err = 1'b1;
          endcase
          // Local commands acknowledge here
          if (next_st == ST_IDLE) begin
            next_done = 1'b1;
          end
        end
      end
      // Byte loops, local or through the synthesizer port
      ST_XFER: begin
        case (kind)
          XK_BWRITE: begin
            buf_we = 1'b1;
            buf_wdata = cmd_data[idx[2:0]];
            step = 1'b1;
          end
          XK_BREAD: begin
            next_resp[idx[2:0]] = buf_rd;
            step = 1'b1;
          end
          default: begin
            if (!req_valid) begin
              next_req_valid = 1'b1;
              next_req.inst = inst;
              next_req.addr = base + {7'h0, idx};
              next_req.we = (kind == XK_DWRITE) || (kind == XK_COMMIT);
              // Commit sends every held byte of the bank
              next_req.wdata = (kind == XK_COMMIT) ? buf_rd
                : cmd_data[idx[2:0]];
            end else if (synth_ack_in) begin
              next_req_valid = 1'b0;
              step = 1'b1;
              if (kind == XK_DREAD) begin
                next_resp[idx[2:0]] = synth_rdata_in;
              end
              if (kind == XK_READBACK) begin
                buf_we = 1'b1;
                buf_wdata = synth_rdata_in;
              end
            end
          end
        endcase
        // Acknowledge only after the last byte
        if (step) begin
          next_idx = idx + 8'h01;
          if (xfer_last) begin
            next_done = 1'b1;
            next_st = ST_IDLE;
          end
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // Engine registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= ST_IDLE;
      op <= OP_READBACK;
      inst <= 3'h0;
      kind <= XK_READBACK;
      idx <= 8'h0;
      cnt <= 8'h0;
      base <= 15'h0;
      for (int i = 0; i < 8; i++) begin
        path_cfg[i] <= '0;
        path_cfg[i].lo_src <= lsc_lo_src_t'(`LSC_RST_LO_SRC);
      end
      for (int i = 0; i < 4; i++) begin
        ref_cfg[i].src <= lsc_ref_src_t'(`LSC_RST_REF_SRC);
        ref_cfg[i].mode <= RMODE_OFF;
      end
      req <= '0;
      req_valid <= 1'b0;
      done_flag <= 1'b0;
      err_flag <= 1'b0;
      resp <= 64'h0;
      result <= 32'h0;
    end else begin
      st <= next_st;
      op <= next_op;
      inst <= next_inst;
      kind <= next_kind;
      idx <= next_idx;
      cnt <= next_cnt;
      base <= next_base;
      path_cfg <= next_path_cfg;
      ref_cfg <= next_ref_cfg;
      req <= next_req;
      req_valid <= next_req_valid;
      done_flag <= next_done;
      err_flag <= next_err;
      resp <= next_resp;
      result <= next_result;
    end
  end

  // Outputs straight from registers
  assign synth_req_out = req;
  assign synth_valid_out = req_valid;
  assign path_cfg_out = path_cfg;
  assign ref_cfg_out = ref_cfg;
  assign busy_out = (st != ST_IDLE);

  // Connector driven only in the two output modes
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ref
      assign ref_conn_oe_out[g] = (ref_cfg[g].mode != RMODE_OFF);
      a_ref_outside_off: assert property (@(posedge mclk_in)
        disable iff (!rst_n_in) (ref_cfg[g].src == REF_OUTSIDE_CONNECTOR)
        |-> !ref_conn_oe_out[g]) else $error("ref output with outside");
    end
  endgenerate

  // ==========================================================
  // Checks
  // ==========================================================
  a_addr_ascend: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (synth_valid_out && synth_ack_in && !xfer_last)
    |=> ##1 (synth_valid_out && (synth_req_out.addr ==
      $past(synth_req_out.addr, 2) + 15'h1)))
    else $error("synth address not ascending");
  a_bwrite_local: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (st == ST_XFER && kind == XK_BWRITE) |-> !synth_valid_out)
    else $error("buffered write reached synth");
  a_bread_local: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (st == ST_XFER && kind == XK_BREAD) |-> !synth_valid_out)
    else $error("buffered read reached synth");
  a_commit_writes: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (synth_valid_out && kind == XK_COMMIT) |-> (synth_req_out.we
      && synth_req_out.wdata == buf_mem[{inst, synth_req_out.addr[6:0]}]))
    else $error("commit byte differs from buffer");
  a_readback_reads: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (synth_valid_out && kind == XK_READBACK) |-> !synth_req_out.we)
    else $error("readback issued a write");
  a_err_keeps: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (st == ST_EXEC && chk_err) |=> (path_cfg == $past(path_cfg)
      && ref_cfg == $past(ref_cfg) && err_flag && done_flag && !busy_out))
    else $error("rejected command changed state");
  a_primary_role: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (st == ST_EXEC && op == OP_REF && cmd_arg[1:0] == REF_PRIMARY
      && !follower) |=> (err_flag && $stable(ref_cfg)))
    else $error("primary reference taken as leader");
  a_done_last: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (st == ST_XFER && step && xfer_last) |=> (done_flag && !busy_out))
    else $error("acknowledge missing after last byte");
  a_lofreq_seq: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    (st == ST_EXEC && op == OP_LO_FREQ && !chk_err)
    |=> (path_cfg[inst].lo_src == LO_DOUBLED_SYNTH
      && path_cfg[inst].rf16_en && kind == XK_COMMIT)
    ##1 (synth_valid_out && synth_req_out.we))
    else $error("LO frequency sequence broken");
endmodule
`default_nettype wire

// ==== src/lsc_params.svh ====
// Offsets, field positions, reset values and limits of the LO console block
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH
// Wishbone byte offsets, one 32-bit word per register
`define LSC_OFF_CMD 6'h00
`define LSC_OFF_ADDR 6'h04
`define LSC_OFF_DATA0 6'h08
`define LSC_OFF_DATA1 6'h0C
`define LSC_OFF_ARG 6'h10
`define LSC_OFF_STATUS 6'h14
`define LSC_OFF_RESP0 6'h18
`define LSC_OFF_RESP1 6'h1C
`define LSC_OFF_RESULT 6'h20
`define LSC_OFF_ROLE 6'h24
// Field positions
`define LSC_CMD_GO_BIT 31
`define LSC_CMD_PATH_BIT 6
`define LSC_ADDR_CNT_LSB 16
`define LSC_REF_MODE_LSB 4
// Argument limits
`define LSC_MAX_BYTES 4'h8
`define LSC_FREQ_MIN_KHZ 26'd21600000
`define LSC_FREQ_MAX_KHZ 26'd41000000
`define LSC_BW_SPLIT_KHZ 26'd31000000
`define LSC_LO_MULT_SHIFT 3
// Bytes held per synthesizer in the buffered copy
`define LSC_BUF_DEPTH 8'h80
// Reset values
`define LSC_RST_REF_SRC 2'h1
`define LSC_RST_LO_SRC 2'h1
`endif

// ==== src/lsc_pkg.sv ====
// Types shared by the LO console command engine
`default_nettype none
package lsc_pkg;
  // Engine states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_XFER = 3'h4
  } lsc_state_t;
  // Command codes written to the command register
  typedef enum logic [3:0] {
    OP_READBACK = 4'h0, OP_DWRITE = 4'h1, OP_DREAD = 4'h2,
    OP_BWRITE = 4'h3, OP_BREAD = 4'h4, OP_COMMIT = 4'h5,
    OP_LO_FREQ = 4'h6, OP_LO_FREQ_Q = 4'h7, OP_LO_SRC = 4'h8,
    OP_LO_SRC_Q = 4'h9, OP_REF = 4'hA, OP_REF_Q = 4'hB
  } lsc_op_t;
  // Kinds of byte transfer loops
  typedef enum logic [2:0] {
    XK_READBACK = 3'h0, XK_DWRITE = 3'h1, XK_DREAD = 3'h2,
    XK_COMMIT = 3'h3, XK_BWRITE = 3'h4, XK_BREAD = 3'h5
  } lsc_xfer_t;
  // LO source per channel and path
  typedef enum logic [1:0] {
    LO_OUTSIDE_CONNECTOR = 2'h0, LO_SYNTH = 2'h1, LO_DOUBLED_SYNTH = 2'h2
  } lsc_lo_src_t;
  // Reference source per channel
  typedef enum logic [1:0] {
    REF_OUTSIDE_CONNECTOR = 2'h0, REF_ONBOARD = 2'h1, REF_PRIMARY = 2'h2
  } lsc_ref_src_t;
  // Reference connector mode
  typedef enum logic [1:0] {
    RMODE_OFF = 2'h0, RMODE_SQUARE = 2'h1, RMODE_SMOOTH_WAVE = 2'h2
  } lsc_ref_mode_t;
  // Settings of one synthesizer instance
  typedef struct packed {
    lsc_lo_src_t lo_src;
    logic filt_wide;
    logic rf8_en;
    logic rf16_en;
    logic [22:0] out_khz;
    logic [25:0] lo_khz;
  } lsc_path_cfg_t;
  // Reference routing of one channel
  typedef struct packed {
    lsc_ref_src_t src;
    lsc_ref_mode_t mode;
  } lsc_ref_cfg_t;
  // One byte access toward a synthesizer
  typedef struct packed {
    logic [2:0] inst;
    logic we;
    logic [14:0] addr;
    logic [7:0] wdata;
  } lsc_synth_req_t;
endpackage
`default_nettype wire

// ==== verif/lsc_synth_model.sv ====
// Behavioural synthesizer answering byte transfers
`default_nettype none
module lsc_synth_model
  import lsc_pkg::*;
(
  input wire logic mclk_in,
  input wire lsc_pkg::lsc_synth_req_t req_in,
  input wire logic valid_in,
  input wire logic [3:0] wait_in,
  output logic ack_out,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Register space of all eight instances, keyed {inst,addr}
  logic [7:0] mem [logic [17:0]];
  logic [3:0] cnt = 4'h0;
  initial ack_out = 1'b0;
  initial rdata_out = 8'h00;
  // =====================
  // Answer after wait_in cycles
  always @(posedge mclk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out; // Stale data never holds
    if (valid_in && !ack_out) begin
      if (cnt < wait_in) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        ack_out <= 1'b1;
        if (req_in.we) begin
          mem[{req_in.inst, req_in.addr}] = req_in.wdata;
        end else if (mem.exists({req_in.inst, req_in.addr})) begin
          rdata_out <= mem[{req_in.inst, req_in.addr}];
        end else begin
          rdata_out <= req_in.addr[7:0] ^ 8'h5A;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/lsc_lo_console_test.sv ====
// Self-checking bench for the LO console engine
`default_nettype none
module lsc_lo_console_test;
  timeunit 1ns;
  timeprecision 100ps;
  import lsc_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, dat = 32'h0, rd, dout;
  logic [3:0] wt = 4'h0, oe;
  logic ack, sv, sa, busy;
  logic [7:0] srd;
  lsc_synth_req_t req;
  lsc_path_cfg_t [7:0] pc;
  lsc_ref_cfg_t [3:0] rc;
  int mismatches = 0, checks_done = 0;
  always #2.5 mclk = ~mclk;
  lsc_lo_console uut (.mclk_in(mclk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat),
    .wb_sel_in(4'hF), .wb_dat_out(dout), .wb_ack_out(ack),
    .synth_req_out(req), .synth_valid_out(sv), .synth_ack_in(sa),
    .synth_rdata_in(srd), .path_cfg_out(pc), .ref_cfg_out(rc),
    .ref_conn_oe_out(oe), .busy_out(busy));
  lsc_synth_model syn (.mclk_in(mclk), .req_in(req), .valid_in(sv),
    .wait_in(wt), .ack_out(sa), .rdata_out(srd));
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // =====================
  // One classic Wishbone cycle
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {26'h0, a};
    dat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        conclude();
      end
      @(posedge mclk);
    end
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Launch, wait for idle, check done/error flags
  task automatic run(input logic [3:0] op, input logic [2:0] i,
                     input logic err);
    int n;
    n = 0;
    bus(1'b1, 6'h00, {1'b1, 24'h0, i[0], i[2:1], op});
    @(posedge mclk);
    while (busy !== 1'b0) begin
      n++;
      if (n > 4000) begin
        mismatches++;
        conclude();
      end
      @(posedge mclk);
    end
    bus(1'b0, 6'h14, 32'h0);
    chk("status", err ? 32'h6 : 32'h2, rd);
  endtask
  task automatic ad(input logic [14:0] a, input logic [3:0] c);
    bus(1'b1, 6'h04, {12'h0, c, 1'b0, a});
  endtask
  task automatic rsp(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("response", e, rd);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("ref src", 32'(REF_ONBOARD), 32'(rc[0].src));
    rsp(6'h3C, 32'h0);
    wt <= 4'h3;
    run(OP_READBACK, 3'h0, 1'b0);
    ad(15'h10, 4'h4);
    run(OP_BREAD, 3'h0, 1'b0);
    rsp(6'h18, 32'h49484B4A);
    bus(1'b1, 6'h08, 32'hD4C3B2A1);
    ad(15'h7C, 4'h4);
    run(OP_BWRITE, 3'h0, 1'b0);
    run(OP_BREAD, 3'h0, 1'b0);
    rsp(6'h18, 32'hD4C3B2A1);
    run(OP_DREAD, 3'h0, 1'b0);
    rsp(6'h18, 32'h25242726);
    run(OP_COMMIT, 3'h0, 1'b0);
    run(OP_DREAD, 3'h0, 1'b0);
    rsp(6'h18, 32'hD4C3B2A1);
    wt <= 4'h0;
    bus(1'b1, 6'h08, 32'h44332211);
    bus(1'b1, 6'h0C, 32'h88776655);
    ad(15'h7FF8, 4'h8);
    run(OP_DWRITE, 3'h5, 1'b0);
    run(OP_DREAD, 3'h5, 1'b0);
    rsp(6'h18, 32'h44332211);
    rsp(6'h1C, 32'h88776655);
    run(OP_DREAD, 3'h4, 1'b0);
    rsp(6'h18, 32'hA1A0A3A2);
    ad(15'h0, 4'h0);
    run(OP_DWRITE, 3'h0, 1'b1);
    ad(15'h0, 4'h9);
    run(OP_DREAD, 3'h0, 1'b1);
    ad(15'h7D, 4'h4);
    run(OP_BWRITE, 3'h0, 1'b1);
    run(4'hC, 3'h0, 1'b1);
    run(OP_READBACK, 3'h3, 1'b0);
    bus(1'b1, 6'h10, 32'd41000000);
    run(OP_LO_FREQ, 3'h3, 1'b0);
    chk("lo cfg", {2'(LO_DOUBLED_SYNTH), 3'b101, 23'd5125000},
        pc[3][53:26]);
    run(OP_LO_FREQ_Q, 3'h3, 1'b0);
    rsp(6'h20, 32'd41000000);
    bus(1'b1, 6'h10, 32'd41000001);
    run(OP_LO_FREQ, 3'h3, 1'b1);
    bus(1'b1, 6'h10, 32'd21599999);
    run(OP_LO_FREQ, 3'h3, 1'b1);
    chk("lo khz", 32'd41000000, 32'(pc[3].lo_khz));
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 6'h10, 32'(s));
      run(OP_LO_SRC, 3'h6, s == 3);
      run(OP_LO_SRC_Q, 3'h6, 1'b0);
      rsp(6'h20, s == 3 ? 32'h2 : 32'(s));
    end
    bus(1'b1, 6'h10, 32'h12);
    run(OP_REF, 3'h2, 1'b1);
    bus(1'b1, 6'h24, 32'h1);
    run(OP_REF, 3'h2, 1'b0);
    chk("conn oe", 32'h2, 32'(oe));
    run(OP_REF_Q, 3'h2, 1'b0);
    rsp(6'h20, 32'h12);
    bus(1'b1, 6'h10, 32'h10);
    run(OP_REF, 3'h2, 1'b1);
    bus(1'b1, 6'h10, 32'h23);
    run(OP_REF, 3'h2, 1'b1);
    bus(1'b1, 6'h10, 32'h0);
    run(OP_REF, 3'h2, 1'b0);
    chk("conn oe", 32'h0, 32'(oe));
    conclude();
  end
endmodule
`default_nettype wire
